// File: inc/rx_ring_pkg.sv
// Purpose: shared constants and carriers for the receive ring and header-split block
// Assumes: one queue, 32-bit register port, byte offsets
// Notes: descriptor indices are counted in 16-byte blocks
package rx_ring_pkg;
   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [7:0] OFS_BASE_LO = 8'h00;
   localparam logic [7:0] OFS_BASE_HI = 8'h04;
   localparam logic [7:0] OFS_LEN = 8'h08;
   localparam logic [7:0] OFS_HEAD = 8'h0C;
   localparam logic [7:0] OFS_TAIL = 8'h10;
   localparam logic [7:0] OFS_SPLIT_CTL = 8'h14;
   localparam logic [7:0] OFS_TYPE_SEL = 8'h18;
   localparam logic [7:0] OFS_CTL = 8'h1C;
   localparam logic [7:0] OFS_STATUS = 8'h20;
   // ****************************************************************
   // Field layout and constants
   // ****************************************************************
   localparam int DESC_SHIFT = 4;
   localparam int LEN_ALIGN_BITS = 7;
   localparam int FMT_LSB = 25;
   localparam int THR_LSB = 22;
   localparam int HDRSZ_LSB = 8;
   localparam int PKTSZ_LSB = 0;
   localparam int THR_UNIT_SHIFT = 6;
   localparam logic [9:0] MAX_SPLIT_HDR = 10'h3FF;
   localparam logic [2:0] FMT_LEGACY = 3'h0;
   localparam logic [2:0] FMT_ADV = 3'h1;
   localparam logic [2:0] FMT_HSPLIT = 3'h2;
   localparam logic [2:0] FMT_ALWAYS = 3'h5;
   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic [31:0] addr_lo;
      logic [31:0] addr_hi;
      logic [15:0] parsed_header_length;
      logic [15:0] posted_packet_length;
      logic [3:0] ptype;
      logic ip_in_ip;
      logic eop;
   } rx_pkt_s;
   typedef struct packed {
      logic [63:0] addr;
      logic [15:0] hdr_bytes;
      logic [15:0] data_bytes;
      logic split;
      logic hdr_overflow;
      logic descriptor_done;
      logic eop;
   } wb_req_s;
   typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_WBACK} dma_state_e;
endpackage : rx_ring_pkg

// File: core/rx_ring_split.sv
// Purpose: receive descriptor ring pointers and header-split decision for one queue
// Assumes: one packet offered at a time; write path accepts in order
// Notes: data writes then descriptor write-back go on one write port
// Behaviour
// R1: Tail write sets internal tail
// R2: Head advances as packets stored
// R3: Visible head tracks or waits interrupt
// R4: Head equals tail stops storing
// R5: Write-back first, then head increments
// R6: Pointers wrap at ring size
// R7: Pointers index 16-byte descriptors
// R8: Consumed descriptors get done bit
// R9: Device touches only head-to-tail descriptors
// R10: Base is 64-bit, low 4 ignored
// R11: Length multiple of 128 bytes; code takes any 16-byte multiple
// R12: Data writes precede descriptor updates
// R13: Software configures before enable
// R14: Low free descriptors raise interrupt
// R15: Format select decodes split modes
// R16: Split-always puts leading bytes in header
// R17: Header buffer holds only header
// R18: Split only selected packet types
// R19: No split past 1023-byte header
// R20: No split for IP-in-IP packets
// R21: Oversized header sets overflow flag
// R22: Only first descriptor's header buffer
// R23: Overflowed packets still posted
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
module rx_ring_split
   import rx_ring_pkg::*;
#(
   parameter int IDX_W = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Packet offer
   input wire logic pkt_valid,
   input wire rx_pkt_s pkt_in,
   input wire logic [3:0] pool_sel,
   output logic pkt_ready,
   // Write path
   output logic wr_valid,
   output wb_req_s wr_req,
   output logic wr_is_desc,
   input wire logic wr_ready,
   // Events
   input wire logic queue_irq,
   output logic low_free_irq
);
   initial begin
      if (IDX_W < 4 || IDX_W > 16) begin
         $error("IDX_W out of range");
      end
   end

   typedef struct packed {
      logic [31:0] base_lo;
      logic [31:0] base_hi;
      logic [IDX_W-1:0] len_desc;
      logic [IDX_W-1:0] head;
      logic [IDX_W-1:0] vis_head;
      logic [IDX_W-1:0] tail;
      logic [31:0] split_ctl;
      logic [15:0] type_sel;
      logic enable;
      logic coalesce;
      logic virt_on;
      logic hdr_used;
      dma_state_e st;
      wb_req_s req;
      logic [IDX_W-1:0] slot;
      logic [31:0] rdata;
      logic irq;
      logic ready;
      // Write-path outputs kept as flops, not decoded from the state
      logic busy;
      logic desc_phase;
   } state_s;

   state_s s_r, s_nxt;
   logic [2:0] fmt;
   logic [15:0] hdr_sz;
   logic [IDX_W-1:0] free_cnt, thr_cnt, head_inc;
   logic empty, splitting, type_ok, header_overflow_flag, do_split;

   always_comb begin
      fmt = s_r.split_ctl[FMT_LSB +: 3];
      hdr_sz = {6'h00, s_r.split_ctl[HDRSZ_LSB +: 10]};
      // R4 empty queue
      empty = (s_r.head == s_r.tail);
      // R14 free distance
      free_cnt = (s_r.tail >= s_r.head) ? IDX_W'(s_r.tail - s_r.head)
         : IDX_W'(s_r.len_desc - s_r.head + s_r.tail);
      thr_cnt = IDX_W'(s_r.split_ctl[THR_LSB +: 3]) << THR_UNIT_SHIFT;
      // R15 format decode
      splitting = (fmt > FMT_ADV);
      // R18 type selection
      type_ok = s_r.virt_on ? s_r.type_sel[pool_sel] : s_r.type_sel[0];
      type_ok = type_ok && (pkt_in.ptype != 4'h0) && s_r.type_sel[pkt_in.ptype];
      // R21 overflow flag
      header_overflow_flag = (pkt_in.parsed_header_length > hdr_sz);
      // R19 R20 split exclusions
      do_split = splitting && type_ok && !header_overflow_flag && !pkt_in.ip_in_ip
         && (pkt_in.parsed_header_length <= {6'h00, MAX_SPLIT_HDR}) && !s_r.hdr_used;
      // R6 wrap increment
      head_inc = (s_r.head + 1'b1 >= s_r.len_desc) ? '0 : IDX_W'(s_r.head + 1'b1);
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.rdata = 32'h0000_0000;
      // ****************************************************************
      // Register writes and reads
      // ****************************************************************
      if (reg_wr) begin
         case (reg_addr)
            // R10 base alignment
            OFS_BASE_LO: s_nxt.base_lo = {reg_wdata[31:DESC_SHIFT], 4'h0};
            OFS_BASE_HI: s_nxt.base_hi = reg_wdata;
            // R11 length in descriptors
            OFS_LEN: s_nxt.len_desc = IDX_W'(reg_wdata[31:DESC_SHIFT]);
            // R1 tail update
            OFS_TAIL: s_nxt.tail = IDX_W'(reg_wdata);
            OFS_SPLIT_CTL: s_nxt.split_ctl = reg_wdata;
            OFS_TYPE_SEL: s_nxt.type_sel = reg_wdata[15:0];
            OFS_CTL: begin
               s_nxt.enable = reg_wdata[0];
               s_nxt.coalesce = reg_wdata[1];
               s_nxt.virt_on = reg_wdata[2];
            end
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            OFS_BASE_LO: s_nxt.rdata = s_r.base_lo;
            OFS_BASE_HI: s_nxt.rdata = s_r.base_hi;
            OFS_LEN: s_nxt.rdata = 32'(s_r.len_desc) << DESC_SHIFT;
            OFS_HEAD: s_nxt.rdata = 32'(s_r.vis_head);
            OFS_TAIL: s_nxt.rdata = 32'(s_r.tail);
            OFS_SPLIT_CTL: s_nxt.rdata = s_r.split_ctl;
            OFS_TYPE_SEL: s_nxt.rdata = {16'h0000, s_r.type_sel};
            OFS_CTL: s_nxt.rdata = {29'h0, s_r.virt_on, s_r.coalesce, s_r.enable};
            OFS_STATUS: s_nxt.rdata = {30'h0, empty, s_r.st != ST_IDLE};
            default: s_nxt.rdata = 32'h0000_0000;
         endcase
      end
      // ****************************************************************
      // Store engine
      // ****************************************************************
      s_nxt.ready = 1'b0;
      case (s_r.st)
         ST_IDLE: begin
            // R4 R9 R13 only owned descriptors
            if (pkt_valid && s_r.enable && !empty && !s_r.ready) begin
               s_nxt.ready = 1'b1;
               s_nxt.slot = s_r.head;
               // R7 descriptor address
               s_nxt.req.addr = {s_r.base_hi, s_r.base_lo}
                  + (64'(s_r.head) << DESC_SHIFT);
               s_nxt.req.split = do_split;
               // R23 overflow still posted
               s_nxt.req.hdr_overflow = splitting && header_overflow_flag;
               s_nxt.req.eop = pkt_in.eop;
               s_nxt.req.descriptor_done = 1'b0;
               // R16 R17 header buffer share
               if (do_split) begin
                  s_nxt.req.hdr_bytes = pkt_in.parsed_header_length;
                  s_nxt.req.data_bytes = pkt_in.posted_packet_length - pkt_in.parsed_header_length;
               end else if (fmt == FMT_ALWAYS && !s_r.hdr_used) begin
                  s_nxt.req.hdr_bytes = (pkt_in.posted_packet_length < hdr_sz) ? pkt_in.posted_packet_length : hdr_sz;
                  s_nxt.req.data_bytes = pkt_in.posted_packet_length - s_nxt.req.hdr_bytes;
               end else begin
                  s_nxt.req.hdr_bytes = 16'h0000;
                  s_nxt.req.data_bytes = pkt_in.posted_packet_length;
               end
               // R22 first descriptor only
               s_nxt.hdr_used = !pkt_in.eop;
               s_nxt.st = ST_DATA;
               s_nxt.busy = 1'b1;
            end
         end
         // R12 data first
         ST_DATA: if (wr_ready) begin
            s_nxt.req.descriptor_done = 1'b1;
            s_nxt.st = ST_WBACK;
            s_nxt.desc_phase = 1'b1;
         end
         // R5 R8 write-back then head
         ST_WBACK: if (wr_ready) begin
            // R2 R6 head advance
            s_nxt.head = head_inc;
            s_nxt.st = ST_IDLE;
            s_nxt.busy = 1'b0;
            s_nxt.desc_phase = 1'b0;
         end
         default: begin
            s_nxt.st = ST_IDLE;
            s_nxt.busy = 1'b0;
            s_nxt.desc_phase = 1'b0;
         end
      endcase
      // Coalescing holds the visible copy until the queue interrupt
      // R3 visible head
      if (!s_r.coalesce || queue_irq) begin
         s_nxt.vis_head = s_r.head;
      end
      // R14 low free interrupt
      s_nxt.irq = s_r.enable && (thr_cnt != '0) && (free_cnt <= thr_cnt);
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata = s_r.rdata;
   assign pkt_ready = s_r.ready;
   assign wr_valid = s_r.busy;
   assign wr_req = s_r.req;
   assign wr_is_desc = s_r.desc_phase;
   assign low_free_irq = s_r.irq;

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_empty_stall;
      @(posedge mclk) disable iff (sys_rst) (s_r.head == s_r.tail) |=> !pkt_ready;
   endproperty
   a_empty_stall: assert property (p_empty_stall) else $error("store while empty"); // R4
   property p_order;
      @(posedge mclk) disable iff (sys_rst)
         (s_r.st == ST_DATA && wr_ready) |=> (wr_is_desc && wr_req.descriptor_done);
   endproperty
   a_order: assert property (p_order) else $error("descriptor not after data"); // R12
   property p_head_after_wb;
      @(posedge mclk) disable iff (sys_rst)
         (s_r.head != $past(s_r.head)) |-> $past(wr_is_desc && wr_ready);
   endproperty
   a_head_after_wb: assert property (p_head_after_wb) else $error("head moved early"); // R5
   property p_tail;
      @(posedge mclk) disable iff (sys_rst)
         (reg_wr && reg_addr == OFS_TAIL) |=> (s_r.tail == $past(reg_wdata[IDX_W-1:0]));
   endproperty
   a_tail: assert property (p_tail) else $error("tail not taken"); // R1
   property p_wrap;
      @(posedge mclk) disable iff (sys_rst) s_r.len_desc != '0 && s_r.head < s_r.len_desc
         |=> (s_r.head < s_r.len_desc) || s_r.len_desc != $past(s_r.len_desc);
   endproperty
   a_wrap: assert property (p_wrap) else $error("head past ring"); // R6
   property p_vis;
      @(posedge mclk) disable iff (sys_rst) !s_r.coalesce ##1 !s_r.coalesce
         |-> s_r.vis_head == $past(s_r.head);
   endproperty
   a_vis: assert property (p_vis) else $error("visible head lags"); // R3
   property p_base;
      @(posedge mclk) disable iff (sys_rst) s_r.base_lo[3:0] == 4'h0;
   endproperty
   a_base: assert property (p_base) else $error("base low bits kept"); // R10
   property p_hbo;
      @(posedge mclk) disable iff (sys_rst) pkt_ready && s_r.req.hdr_overflow |-> !s_r.req.split;
   endproperty
   a_hbo: assert property (p_hbo) else $error("overflowed header split"); // R21
   property p_valid_state;
      @(posedge mclk) disable iff (sys_rst)
         wr_valid == (s_r.st != ST_IDLE) && wr_is_desc == (s_r.st == ST_WBACK);
   endproperty
   a_valid_state: assert property (p_valid_state) else $error("write flags off state"); // R12
   property p_head_step;
      @(posedge mclk) disable iff (sys_rst)
         (s_r.st == ST_WBACK && wr_ready) |=> s_r.head == $past(head_inc);
   endproperty
   a_head_step: assert property (p_head_step) else $error("head did not step"); // R2
   property p_head_ro;
      @(posedge mclk) disable iff (sys_rst)
         (reg_wr && reg_addr == OFS_HEAD && s_r.st != ST_WBACK) |=> s_r.head == $past(s_r.head);
   endproperty
   a_head_ro: assert property (p_head_ro) else $error("head moved by software"); // R5
   property p_done_bit;
      @(posedge mclk) disable iff (sys_rst)
         wr_is_desc |-> wr_req.descriptor_done;
   endproperty
   a_done_bit: assert property (p_done_bit) else $error("write-back without done bit"); // R8
   property p_desc_align;
      @(posedge mclk) disable iff (sys_rst)
         wr_valid |-> wr_req.addr[DESC_SHIFT-1:0] == '0;
   endproperty
   a_desc_align: assert property (p_desc_align) else $error("descriptor address unaligned"); // R7
   property p_owned;
      @(posedge mclk) disable iff (sys_rst)
         $rose(wr_valid) |-> $past(s_r.head != s_r.tail && s_r.enable);
   endproperty
   a_owned: assert property (p_owned) else $error("store outside owned range"); // R9
   property p_low_free;
      @(posedge mclk) disable iff (sys_rst)
         low_free_irq == $past(s_r.enable && thr_cnt != '0 && free_cnt <= thr_cnt);
   endproperty
   a_low_free: assert property (p_low_free) else $error("low free interrupt wrong"); // R14
   // ****************************************************************
   // Split decision checks
   // ****************************************************************
   property p_fmt_split;
      @(posedge mclk) disable iff (sys_rst)
         pkt_ready && wr_req.split |-> $past(fmt) > FMT_ADV;
   endproperty
   a_fmt_split: assert property (p_fmt_split) else $error("split in non-split format"); // R15
   property p_type;
      @(posedge mclk) disable iff (sys_rst)
         pkt_ready && wr_req.split |-> $past(s_r.type_sel[pkt_in.ptype]);
   endproperty
   a_type: assert property (p_type) else $error("split of unselected type"); // R18
   property p_big_hdr;
      @(posedge mclk) disable iff (sys_rst)
         pkt_ready && $past(pkt_in.parsed_header_length) > 16'(MAX_SPLIT_HDR) |-> !wr_req.split;
   endproperty
   a_big_hdr: assert property (p_big_hdr) else $error("long header split"); // R19
   property p_tunnel;
      @(posedge mclk) disable iff (sys_rst)
         pkt_ready && $past(pkt_in.ip_in_ip) |-> !wr_req.split;
   endproperty
   a_tunnel: assert property (p_tunnel) else $error("tunneled packet split"); // R20
   property p_split_len;
      @(posedge mclk) disable iff (sys_rst)
         pkt_ready && wr_req.split |-> wr_req.hdr_bytes == $past(pkt_in.parsed_header_length);
   endproperty
   a_split_len: assert property (p_split_len) else $error("header share wrong"); // R17
   property p_always_hdr;
      @(posedge mclk) disable iff (sys_rst)
         pkt_ready && !wr_req.split && $past(fmt == FMT_ALWAYS && !s_r.hdr_used)
            && $past(hdr_sz != '0 && pkt_in.posted_packet_length != '0) |-> wr_req.hdr_bytes != '0;
   endproperty
   a_always_hdr: assert property (p_always_hdr) else $error("leading bytes not in header"); // R16
   property p_first_hdr;
      @(posedge mclk) disable iff (sys_rst)
         pkt_ready && $past(s_r.hdr_used) |-> wr_req.hdr_bytes == '0;
   endproperty
   a_first_hdr: assert property (p_first_hdr) else $error("header buffer reused"); // R22
   property p_hbo_post;
      @(posedge mclk) disable iff (sys_rst)
         pkt_ready && wr_req.hdr_overflow |-> wr_valid;
   endproperty
   a_hbo_post: assert property (p_hbo_post) else $error("overflowed packet dropped"); // R23
endmodule : rx_ring_split

// File: verification/rx_mem_model.sv
// Purpose: system memory side of the write path
// Assumes: writes are taken in the order offered
// Notes: random stalls stretch every data transfer and about one write-back in three
`timescale 1ns/1ps
module rx_mem_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Write path
   input wire logic wr_valid,
   output logic wr_ready
);
   // Ready is never held high for long, so a design that ignores it shows up
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst)
         wr_ready <= 1'b0;
      else
         wr_ready <= wr_valid && ($urandom % 3 != 0);
   end
endmodule : rx_mem_model

// File: verification/test_rx_ring_split.sv
// Purpose: self-checking bench for the receive ring and split block
// Assumes: ring of 128 bytes, so 8 descriptors
// Notes: descriptor write-backs are scored against a queue of notes
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
   $display("Error at %0t: got %h expected %h", $time, a, b); end end
module test_rx_ring_split
   import rx_ring_pkg::*;
;
   typedef struct packed {
      logic [63:0] addr;
      logic split;
      logic header_overflow_flag;
      logic [15:0] hdr_b;
      logic [15:0] pkt_b;
      logic eop;
   } exp_s;
   logic mclk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic pkt_valid = 1'b0, queue_irq = 1'b0, rd_pend = 1'b0, last_data = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [3:0] pool_sel = 4'h0;
   rx_pkt_s pkt_in = '0;
   logic pkt_ready, wr_valid, wr_is_desc, wr_ready, low_free_irq;
   wb_req_s wr_req;
   exp_s exp_q[$], e;
   logic [31:0] rd_q[$];
   logic [2:0] fm[4] = '{FMT_LEGACY, FMT_ADV, FMT_HSPLIT, FMT_ALWAYS};
   logic [63:0] base = 64'h0000_00AB_1234_5670;
   logic [31:0] rd_x;
   logic [15:0] tsel = 16'hFFFF;
   logic virt = 1'b0, cont = 1'b0;
   int n_mismatch = 0, total_checks = 0, acc_cnt = 0, cyc = 0, hd = 0, old = 0;

   rx_ring_split dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .pkt_valid(pkt_valid), .pkt_in(pkt_in), .pool_sel(pool_sel), .pkt_ready(pkt_ready),
      .wr_valid(wr_valid), .wr_req(wr_req), .wr_is_desc(wr_is_desc), .wr_ready(wr_ready),
      .queue_irq(queue_irq), .low_free_irq(low_free_irq));
   rx_mem_model mem (.mclk(mclk), .sys_rst(sys_rst), .wr_valid(wr_valid),
      .wr_ready(wr_ready));

   always #12.5 mclk = ~mclk;

   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrap_up

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   // ********
   // Watchers
   // ********
   always @(posedge mclk) begin
      rd_pend <= reg_rd;
      if (rd_pend) begin
         rd_x = rd_q.pop_front();
         `CHK(reg_rdata, rd_x)
      end
      if (pkt_ready) acc_cnt++;
      if (wr_valid && wr_ready) begin
         if (wr_is_desc) begin
            e = exp_q.pop_front();
            `CHK(last_data, 1'b1)
            `CHK(wr_req.addr, e.addr)
            `CHK(wr_req.descriptor_done, 1'b1)
            `CHK(wr_req.hdr_overflow, e.header_overflow_flag)
            `CHK(wr_req.split, e.split)
            `CHK(wr_req.hdr_bytes, e.hdr_b)
            `CHK(wr_req.data_bytes, e.pkt_b - e.hdr_b)
            `CHK(wr_req.eop, e.eop)
         end
         last_data = !wr_is_desc;
      end
   end

   // ********
   // Drivers
   // ********
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, input logic [31:0] x);
      rd_q.push_back(x);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
   endtask : reg_read

   task automatic setup_mode(input logic [2:0] fmt, input logic [2:0] thr, input logic [2:0] c);
      reg_write(OFS_CTL, 32'h0);
      reg_write(OFS_SPLIT_CTL, (32'(fmt) << FMT_LSB) | (32'(thr) << THR_LSB) |
         (32'hC8 << HDRSZ_LSB) | 32'h10);
      reg_write(OFS_TYPE_SEL, 32'(tsel));
      reg_write(OFS_CTL, {29'h0, c});
      virt = c[2];
   endtask : setup_mode

   task automatic send(input logic [2:0] fmt, input bit stall);
      rx_pkt_s p;
      int n;
      logic [3:0] pl;
      logic sp;
      logic [15:0] hb;
      p.addr_lo = $urandom;
      p.addr_hi = $urandom;
      p.ptype = 4'($urandom);
      p.parsed_header_length = 16'($urandom % 1100);
      p.posted_packet_length = p.parsed_header_length + 16'h40;
      p.ip_in_ip = ($urandom % 4 == 0);
      p.eop = ($urandom % 3 != 0);
      pl = 4'($urandom);
      // A header never spans buffers, so a split also needs it to fit
      sp = fmt > FMT_ADV && p.ptype != 4'h0 && tsel[p.ptype] && (virt ? tsel[pl] : tsel[0]) &&
         !p.ip_in_ip && p.parsed_header_length <= 16'h3FF && p.parsed_header_length <= 16'hC8 && !cont;
      hb = sp ? p.parsed_header_length : (fmt == FMT_ALWAYS && !cont) ?
         ((p.posted_packet_length < 16'hC8) ? p.posted_packet_length : 16'hC8) : 16'h0000;
      exp_q.push_back(exp_s'{addr: base + 64'(hd * 16), split: sp, hdr_b: hb, pkt_b: p.posted_packet_length,
         header_overflow_flag: fmt > FMT_ADV && p.parsed_header_length > 16'hC8, eop: p.eop});
      cont = !p.eop;
      n = acc_cnt;
      @(posedge mclk);
      pkt_in <= p;
      pkt_valid <= 1'b1;
      pool_sel <= pl;
      if (stall) begin
         repeat (20) @(posedge mclk);
         `CHK(acc_cnt, n)
      end
      reg_write(OFS_TAIL, 32'((hd + 1) % 8));
      for (int i = 0; i < 200 && !pkt_ready; i++) @(posedge mclk);
      pkt_valid <= 1'b0;
      for (int i = 0; i < 400 && wr_valid; i++) @(posedge mclk);
      hd = (hd + 1) % 8;
   endtask : send

   initial begin
      void'($urandom(38));
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      reg_write(OFS_BASE_LO, 32'h1234_567F);
      reg_write(OFS_BASE_HI, 32'h0000_00AB);
      reg_write(OFS_LEN, 32'h80);
      reg_write(OFS_TYPE_SEL, 32'hFFFF_FFFF);
      reg_write(OFS_HEAD, 32'h5);
      reg_read(OFS_BASE_LO, 32'h1234_5670);
      reg_read(OFS_LEN, 32'h80);
      reg_read(8'hFC, 32'h0);
      reg_read(OFS_HEAD, 32'h0);
      foreach (fm[k]) begin
         tsel = 16'($urandom | $urandom);
         setup_mode(fm[k], 3'h1, {1'(k % 2), 2'h1});
         repeat (2) @(posedge mclk);
         `CHK(low_free_irq, 1'b1)
         repeat (6) send(fm[k], 1'b0);
      end
      reg_read(OFS_HEAD, 32'(hd));
      setup_mode(FMT_ADV, 3'h0, 3'h3);
      repeat (2) @(posedge mclk);
      `CHK(low_free_irq, 1'b0)
      old = hd;
      send(FMT_ADV, 1'b1);
      reg_read(OFS_HEAD, 32'(old));
      queue_irq <= 1'b1;
      repeat (3) @(posedge mclk);
      reg_read(OFS_HEAD, 32'(hd));
      repeat (3) @(posedge mclk);
      `CHK(exp_q.size(), 0)
      wrap_up();
   end
endmodule : test_rx_ring_split
